// ---- rtl/efsb_params.svh ----
// Functional notes
// - High side principle is a one-hot nibble: 1 diff, 2 residual, 4 sum, 8 hi-Z.
// - Low side principle is a one-hot nibble: 16, 32, 64, 128 by same order.
// - High-impedance mode only with weight 8 (high) or weight 128 (low).
// - High-impedance start: neutral peak above the side's basic threshold.
// - Harmonic start block never applies in high-impedance mode.
// - Inrush criterion is second harmonic over fundamental of the neutral current.
// - Start is suppressed when blocking enabled and ratio exceeds side limit.
// - Harmonic inhibit only honoured for differential or external-sum principles.
// - Harmonic enable: config switch bit 2 high side, bit 3 low side.
// - Each side's harmonic blocking affects only that side.
// - Uninhibited high start goes to relays in high start mask.
// - Uninhibited low start goes to relays in low start mask.
// - Per side operate delay 0.03 to 100 s, timed from start.
// - Expired high delay drives relays in high operate mask.
// - Operate suppressed while a selected external or intermodular block is active.
// - Expired, uninhibited low delay drives relays in low operate mask.
// - High block indication routed only while high start conditions hold.
// - Low block indication routed only while low start conditions hold.
// - Residual mode start: residual fundamental above the side's basic threshold.
`ifndef EFSB_PARAMS_SVH
`define EFSB_PARAMS_SVH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define EFSB_OFS_PRINC 8'h00
`define EFSB_OFS_CFG 8'h04
`define EFSB_OFS_HI_THR 8'h08
`define EFSB_OFS_LO_THR 8'h0C
`define EFSB_OFS_HI_RLIM 8'h10
`define EFSB_OFS_LO_RLIM 8'h14
`define EFSB_OFS_HI_DLY 8'h18
`define EFSB_OFS_LO_DLY 8'h1C
`define EFSB_OFS_HI_ROUTE 8'h20
`define EFSB_OFS_LO_ROUTE 8'h24
`define EFSB_OFS_INHIB 8'h28
`define EFSB_OFS_STATUS 8'h2C
// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define EFSB_MASK_PRINC 32'h0000_00FF
`define EFSB_MASK_CFG 32'h0000_00FF
`define EFSB_MASK_THR 32'h0000_FFFF
`define EFSB_MASK_RLIM 32'h0000_00FF
`define EFSB_MASK_DLY 32'h0001_FFFF
`define EFSB_MASK_ROUTE 32'h00FF_FFFF
`define EFSB_MASK_INHIB 32'h0000_FFFF
`define EFSB_RST_ZERO 32'h0000_0000
`define EFSB_CFG_HI_HBLK 2
`define EFSB_CFG_LO_HBLK 3
`define EFSB_SIDE_BITS 4
`define EFSB_RELAYS 8
`define EFSB_INHIB_BITS 8
`define EFSB_PCT 8'h64
`define EFSB_RESP_OKAY 2'h0
`define EFSB_RESP_SLVERR 2'h2
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define EFSB_CLK_NS 10
`define EFSB_TICK_NS 1000000
`define EFSB_DLY_MIN_MS 30
`define EFSB_DLY_MAX_MS 100000
`endif

// ---- rtl/efsb_pkg.sv ----
package efsb_pkg;
  // Bit positions inside one side's principle nibble
  typedef enum logic [1:0] {
    EFSB_P_DIFF = 2'b00,
    EFSB_P_RESID = 2'b01,
    EFSB_P_SUM = 2'b10,
    EFSB_P_HIZ = 2'b11
  } efsb_princ_t;
  typedef logic [3:0] efsb_sel_t;
  typedef logic [16:0] efsb_dly_t;
endpackage : efsb_pkg

// ---- rtl/efsb_side.sv ----
`timescale 1ns/10ps
`include "efsb_params.svh"
module efsb_side import efsb_pkg::*; #(parameter int W = 16)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  efsb_side_if.side s
);
  logic onehot;
  logic m_diff;
  logic m_resid;
  logic m_sum;
  logic m_hiz;
  logic [W+7:0] h2_scaled;
  logic [W+7:0] lim_scaled;
  logic ratio_hi;
  logic hblk_ok;
  efsb_dly_t dly;
  efsb_dly_t cnt_q;
  logic done;
  // one-hot check; anything not one-hot disables the side
  assign onehot = (s.sel != 4'h0) && ((s.sel & (s.sel - 4'h1)) == 4'h0);
  assign m_diff = onehot && s.sel[EFSB_P_DIFF];
  assign m_resid = onehot && s.sel[EFSB_P_RESID];
  assign m_sum = onehot && s.sel[EFSB_P_SUM];
  // hi-Z only by its own bit
  assign m_hiz = onehot && s.sel[EFSB_P_HIZ];
  assign s.cond = (m_diff && s.diff_ok) || (m_resid && (s.resid > s.thr))
    || (m_sum && (s.fund > s.thr)) || (m_hiz && (s.peak > s.thr));
  // ratio test in percent, cross-multiplied to avoid a divider
  assign h2_scaled = (W+8)'(s.h2) * (W+8)'(`EFSB_PCT);
  assign lim_scaled = (W+8)'(s.rlim) * (W+8)'(s.fund);
  assign ratio_hi = h2_scaled > lim_scaled;
  // block only for diff or sum principle and when enabled
  assign hblk_ok = s.hblk_en && (m_diff || m_sum) && !m_hiz;
  // suppression uses only this side's inputs
  assign s.hblk = s.cond && hblk_ok && ratio_hi;
  assign s.start = s.cond && !s.hblk;
  // clamp delay to its legal range
  assign dly = (s.dly_ms < efsb_dly_t'(`EFSB_DLY_MIN_MS)) ? efsb_dly_t'(`EFSB_DLY_MIN_MS) :
    (s.dly_ms > efsb_dly_t'(`EFSB_DLY_MAX_MS)) ? efsb_dly_t'(`EFSB_DLY_MAX_MS) : s.dly_ms;
  assign done = (cnt_q >= dly);
  // inhibit masks operate but lets the timer run on
  assign s.operate = s.start && done && !s.inhibit;
  // count ms ticks while started, clear otherwise
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      cnt_q <= '0;
    else if (!s.start)
      cnt_q <= '0;
    else if (s.tick && !done)
      cnt_q <= cnt_q + efsb_dly_t'(1);
  end
endmodule : efsb_side

// ---- rtl/efsb_side_if.sv ----
`timescale 1ns/10ps
interface efsb_side_if #(parameter int W = 16);
  import efsb_pkg::*;
  logic [3:0] sel;
  logic hblk_en;
  logic [W-1:0] thr;
  logic [7:0] rlim;
  efsb_dly_t dly_ms;
  logic [W-1:0] peak;
  logic [W-1:0] fund;
  logic [W-1:0] h2;
  logic [W-1:0] resid;
  logic diff_ok;
  logic inhibit;
  logic tick;
  logic cond;
  logic hblk;
  logic start;
  logic operate;
  modport ctl (output sel, hblk_en, thr, rlim, dly_ms, peak, fund, h2, resid, diff_ok,
    inhibit, tick, input cond, hblk, start, operate);
  modport side (input sel, hblk_en, thr, rlim, dly_ms, peak, fund, h2, resid, diff_ok,
    inhibit, tick, output cond, hblk, start, operate);
endinterface : efsb_side_if

// ---- rtl/efsb_tick.sv ----
`timescale 1ns/10ps
module efsb_tick #(parameter int unsigned CYC = 100000)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  output logic o_tick
);
  logic [31:0] cnt_q;
  logic wrap;
  assign wrap = (cnt_q == 32'(CYC - 1));
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 32'h0000_0000;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      o_tick <= wrap;
    end
  end
endmodule : efsb_tick

// ---- rtl/efsb_top.sv ----
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "efsb_params.svh"
module efsb_top import efsb_pkg::*; #(
  parameter int W = 16,
  parameter int unsigned CYC_PER_MS = `EFSB_TICK_NS / `EFSB_CLK_NS
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0][W-1:0] i_neutral_peak,
  input wire logic [1:0][W-1:0] i_neutral_fund,
  input wire logic [1:0][W-1:0] i_neutral_h2,
  input wire logic [1:0][W-1:0] i_resid_fund,
  input wire logic [1:0] i_diff_start,
  input wire logic [4:0] i_ext_ctrl,
  input wire logic [2:0] i_intermod_block,
  output logic [`EFSB_RELAYS-1:0] o_relay,
  output logic [1:0] o_start,
  output logic [1:0] o_operate,
  output logic [1:0] o_harm_block
);
  localparam int NREG = 11;
  // -----------------------------------------------------------------
  // Register storage
  // -----------------------------------------------------------------
  logic [31:0] reg_q [NREG];
  logic [31:0] wmask [NREG];
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_got_q;
  logic w_got_q;
  logic wr_go;
  logic [31:0] strb_bits;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic rd_stat;
  logic [31:0] rd_mux;
  logic [31:0] status;
  logic [1:0] tick_s;
  logic tick;
  logic [7:0] blk_src;
  logic [1:0] cond;
  logic [1:0] hblk;
  logic [1:0] start;
  logic [1:0] operate;
  logic [`EFSB_RELAYS-1:0] relay_d;

  assign wmask[0] = `EFSB_MASK_PRINC;
  assign wmask[1] = `EFSB_MASK_CFG;
  assign wmask[2] = `EFSB_MASK_THR;
  assign wmask[3] = `EFSB_MASK_THR;
  assign wmask[4] = `EFSB_MASK_RLIM;
  assign wmask[5] = `EFSB_MASK_RLIM;
  assign wmask[6] = `EFSB_MASK_DLY;
  assign wmask[7] = `EFSB_MASK_DLY;
  assign wmask[8] = `EFSB_MASK_ROUTE;
  assign wmask[9] = `EFSB_MASK_ROUTE;
  assign wmask[10] = `EFSB_MASK_INHIB;

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  // Offsets are consecutive words, so the index is the word address
  assign wr_idx = aw_q[5:2];
  assign rd_idx = i_araddr[5:2];
  assign wr_hit = (aw_q[1:0] == 2'h0) && (aw_q < `EFSB_OFS_STATUS);
  assign rd_hit = (i_araddr[1:0] == 2'h0) && (i_araddr < `EFSB_OFS_STATUS);
  assign rd_stat = (i_araddr == `EFSB_OFS_STATUS);
  assign wr_go = aw_got_q && w_got_q && !o_bvalid;
  assign strb_bits = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign status = {24'h00_0000, o_harm_block, o_operate, o_start, 2'h0};
  assign rd_mux = rd_stat ? status : (rd_hit ? reg_q[rd_idx] : 32'h0000_0000);

  genvar r;
  generate
    for (r = 0; r < NREG; r++)
    begin : g_reg
      // Delays reset to the shortest legal value, all else off
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          reg_q[r] <= ((r == 6) || (r == 7)) ? 32'(`EFSB_DLY_MIN_MS) : `EFSB_RST_ZERO;
        else if (wr_go && wr_hit && (wr_idx == 4'(r)))
          reg_q[r] <= ((reg_q[r] & ~strb_bits) | (wd_q & strb_bits)) & wmask[r];
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // AXI4-Lite write channel
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `EFSB_RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_q <= i_awaddr;
        aw_got_q <= 1'b1;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        wd_q <= i_wdata;
        ws_q <= i_wstrb;
        w_got_q <= 1'b1;
        o_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        o_bvalid <= 1'b1;
        // Status writes are accepted and dropped
        o_bresp <= (wr_hit || aw_q == `EFSB_OFS_STATUS) ? `EFSB_RESP_OKAY : `EFSB_RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read channel
  // -----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `EFSB_RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= (rd_hit || rd_stat) ? `EFSB_RESP_OKAY : `EFSB_RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Millisecond time base
  // -----------------------------------------------------------------
  efsb_tick #(.CYC(CYC_PER_MS)) u_tick (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  // -----------------------------------------------------------------
  // Per-side stages, index 0 high voltage, 1 low voltage
  // -----------------------------------------------------------------
  assign blk_src = {i_intermod_block, i_ext_ctrl};
  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_side
      efsb_side_if #(.W(W)) sif ();
      // nibble per side from one switch byte
      assign sif.sel = reg_q[0][s*`EFSB_SIDE_BITS +: `EFSB_SIDE_BITS];
      assign sif.hblk_en = reg_q[1][(s == 0) ? `EFSB_CFG_HI_HBLK : `EFSB_CFG_LO_HBLK];
      assign sif.thr = reg_q[2+s][W-1:0];
      assign sif.rlim = reg_q[4+s][7:0];
      assign sif.dly_ms = reg_q[6+s][16:0];
      assign sif.peak = i_neutral_peak[s];
      assign sif.fund = i_neutral_fund[s];
      assign sif.h2 = i_neutral_h2[s];
      assign sif.resid = i_resid_fund[s];
      assign sif.diff_ok = i_diff_start[s];
      // operate gated by selected block inputs
      assign sif.inhibit = |(blk_src & reg_q[10][s*`EFSB_INHIB_BITS +: `EFSB_INHIB_BITS]);
      assign sif.tick = tick;
      assign cond[s] = sif.cond;
      assign hblk[s] = sif.hblk;
      assign start[s] = sif.start;
      assign operate[s] = sif.operate;
      efsb_side #(.W(W)) u_side (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .s(sif)
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // Relay routing, masks are {block, operate, start} bytes
  // -----------------------------------------------------------------
  // start masks; operate masks; block masks
  assign relay_d = ({`EFSB_RELAYS{start[0]}} & reg_q[8][7:0])
    | ({`EFSB_RELAYS{operate[0]}} & reg_q[8][15:8])
    | ({`EFSB_RELAYS{hblk[0] && cond[0]}} & reg_q[8][23:16])
    | ({`EFSB_RELAYS{start[1]}} & reg_q[9][7:0])
    | ({`EFSB_RELAYS{operate[1]}} & reg_q[9][15:8])
    | ({`EFSB_RELAYS{hblk[1] && cond[1]}} & reg_q[9][23:16]);

  // Outputs are registered; one cycle of latency is harmless at relay speed
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_relay <= '0;
      o_start <= 2'h0;
      o_operate <= 2'h0;
      o_harm_block <= 2'h0;
    end
    else
    begin
      o_relay <= relay_d;
      o_start <= start;
      o_operate <= operate;
      o_harm_block <= hblk;
    end
  end
endmodule : efsb_top

// ---- verif/efsb_checker.sv ----
`timescale 1ns/10ps
module efsb_checker import efsb_pkg::*; #(parameter int unsigned CYC_PER_MS = 4)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [7:0] o_relay,
  input wire logic [1:0] o_start,
  input wire logic [1:0] o_operate,
  input wire logic [1:0] o_harm_block
);
  // ---------------------------------------------
  // Bus and protection path properties
  // ---------------------------------------------
  // Allows two ticks of slack on the 30 ms floor
  localparam int unsigned MIN_RUN = 28 * CYC_PER_MS;
  int unsigned run_q;
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst) run_q <= 0;
    else run_q <= o_start[0] ? run_q + 1 : 0;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_wtake; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence s_bans; ##2 o_bvalid; endsequence
  property p_wresp; s_wtake |-> s_bans; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rresp; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_busy; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_excl; (o_start & o_harm_block) == 2'h0; endproperty
  a_excl: assert property (p_excl) else $error("start while blocked");
  property p_quiet; {o_start, o_operate, o_harm_block} == 6'h0 |-> o_relay == 8'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("relay without cause");
  property p_opdly; $rose(o_operate[0]) |-> run_q >= MIN_RUN; endproperty
  a_opdly: assert property (p_opdly) else $error("operate too early");
  property p_opclr; $fell(o_start[0]) |=> !o_operate[0] [*2]; endproperty
  a_opclr: assert property (p_opclr) else $error("operate after start drop");
endmodule : efsb_checker

bind efsb_top efsb_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.i_mclk, .i_rst, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .i_rready, .o_relay, .o_start, .o_operate, .o_harm_block);

// ---- verif/efsb_relay_model.sv ----
`timescale 1ns/10ps
module efsb_relay_model
(
  input wire logic i_mclk,
  input wire logic [4:0] i_ext_req,
  input wire logic [2:0] i_im_req,
  input wire logic [7:0] i_relay,
  output logic [4:0] o_ext_ctrl = 5'h0,
  output logic [2:0] o_intermod_block = 3'h0,
  output logic [7:0] o_coil = 8'h0
);
  // ---------------------------------------------
  // Far side: blocking sources and relay coils
  // ---------------------------------------------
  // blocking lines change just after an edge
  always @(posedge i_mclk)
  begin
    o_ext_ctrl <= i_ext_req;
    o_intermod_block <= i_im_req;
    // Coils lag their drive by a cycle, like real contacts
    o_coil <= i_relay;
  end
endmodule : efsb_relay_model

// ---- verif/efsb_top_tb.sv ----
`timescale 1ns/10ps
module efsb_top_tb;
  // ---------------------------------------------
  // Bench signals, design and far side
  // ---------------------------------------------
  localparam int CYC = 4;
  logic i_mclk = 0;
  logic i_rst = 1;
  logic [7:0] aw = 0, ar = 0, relay;
  logic [31:0] wd = 0, rdata;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [1:0][15:0] peak = '0, fund = '0, h2 = '0, resid = '0;
  logic [1:0] dstart = 0, bresp, rresp, st, op, hb;
  logic [3:0] ws = 4'hF;
  logic [4:0] ext_req = 0, ext;
  logic [2:0] im_req = 0, im;
  int fails = 0, checked = 0;
  efsb_top #(.CYC_PER_MS(CYC)) DUT (.i_mclk, .i_rst, .i_awaddr(aw), .i_awvalid(awv),
    .o_awready(awrdy), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(ar), .i_arvalid(arv),
    .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_neutral_peak(peak), .i_neutral_fund(fund), .i_neutral_h2(h2),
    .i_resid_fund(resid), .i_diff_start(dstart), .i_ext_ctrl(ext), .i_intermod_block(im),
    .o_relay(relay), .o_start(st), .o_operate(op), .o_harm_block(hb));
  efsb_relay_model PM (.i_mclk, .i_ext_req(ext_req), .i_im_req(im_req), .i_relay(relay),
    .o_ext_ctrl(ext), .o_intermod_block(im), .o_coil());
  initial forever #5 i_mclk = ~i_mclk;
  task automatic wrap_up;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic lim(input bit bad);
    if (bad)
    begin
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up;
    end
  endtask : lim
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    int n;
    n = 0;
    @(posedge i_mclk);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge i_mclk);
      n++;
      if (awrdy) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bvalid && n < 200);
    bready <= 1'h0;
    lim(n >= 200);
    chk(32'(bresp), 32'(e));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
    int n;
    n = 0;
    @(posedge i_mclk);
    ar <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge i_mclk);
      n++;
      if (arrdy) arv <= 1'h0;
    end while (!rvalid && n < 200);
    rready <= 1'h0;
    lim(n >= 200);
    chk(rdata, x);
    chk(32'(rresp), 32'(e));
  endtask : rd
  task automatic wop(input int s, output int n);
    n = 0;
    while (op[s] !== 1'h1 && n < 1000)
    begin
      @(posedge i_mclk);
      n++;
    end
    lim(n >= 1000);
  endtask : wop
  task automatic quiet;
    peak <= '0;
    fund <= '0;
    h2 <= '0;
    resid <= '0;
    dstart <= 2'h0;
    ext_req <= 5'h0;
    im_req <= 3'h0;
    cyc(4);
  endtask : quiet
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_regs;
    rd(8'h18, 32'h1E);
    rd(8'h00, 32'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h31, 32'h1, 2'h2);
    wr(8'h2C, 32'hFF);
    rd(8'h2C, 32'h0);
    // Byte lanes: only the low lane of the second write may land
    wr(8'h08, 32'h1234);
    ws <= 4'h1;
    wr(8'h08, 32'hFFFF);
    ws <= 4'hF;
    rd(8'h08, 32'h12FF);
  endtask : t_regs
  task automatic t_resid;
    int n;
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h64);
    wr(8'h20, 32'h0201);
    resid[0] <= 16'h00C8;
    cyc(3);
    chk(32'(st), 32'h1);
    chk(32'(relay), 32'h1);
    cyc(20 * CYC);
    // Equal to threshold: strict compare drops start
    resid[0] <= 16'h0064;
    cyc(3);
    chk(32'(st), 32'h0);
    resid[0] <= 16'h00C8;
    wop(0, n);
    chk(32'(n >= 28 * CYC && n <= 33 * CYC), 32'h1);
    chk(32'(relay), 32'h3);
    resid[0] <= 16'h0;
    cyc(3);
    chk(32'({op, st}), 32'h0);
    quiet;
  endtask : t_resid
  task automatic t_hiz;
    int n;
    wr(8'h00, 32'h80);
    wr(8'h0C, 32'h64);
    wr(8'h14, 32'hA);
    wr(8'h04, 32'h8);
    wr(8'h24, 32'h0804);
    resid <= {16'h01F4, 16'h01F4};
    fund[1] <= 16'h64;
    h2[1] <= 16'h64;
    peak <= {16'h0064, 16'h0FFF};
    cyc(3);
    chk(32'(st), 32'h0);
    peak[1] <= 16'h0065;
    cyc(3);
    chk(32'({hb, st}), 32'h2);
    chk(32'(relay), 32'h4);
    wop(1, n);
    chk(32'(n >= 28 * CYC), 32'h1);
    chk(32'(relay), 32'hC);
    quiet;
  endtask : t_hiz
  task automatic t_harm;
    wr(8'h00, 32'h11);
    wr(8'h04, 32'h4);
    wr(8'h10, 32'h14);
    wr(8'h14, 32'h14);
    wr(8'h20, 32'h100000);
    wr(8'h24, 32'h400020);
    dstart <= 2'h3;
    fund <= {16'h64, 16'h64};
    h2 <= {16'h1E, 16'h1E};
    cyc(3);
    chk(32'({hb, st}), 32'h6);
    chk(32'(relay), 32'h30);
    h2[0] <= 16'h14;
    cyc(3);
    chk(32'({hb, st}), 32'h3);
    wr(8'h04, 32'h8);
    cyc(2);
    chk(32'({hb, st}), 32'h9);
    chk(32'(relay), 32'h40);
    dstart[1] <= 1'h0;
    cyc(3);
    chk(32'({hb, relay}), 32'h0);
    wr(8'h08, 32'h32);
    wr(8'h0C, 32'h32);
    wr(8'h04, 32'hC);
    wr(8'h00, 32'h22);
    h2 <= {16'h1E, 16'h1E};
    resid <= {16'h64, 16'h64};
    cyc(3);
    chk(32'({hb, st}), 32'h3);
    wr(8'h00, 32'h44);
    cyc(2);
    chk(32'({hb, st}), 32'hC);
    quiet;
  endtask : t_harm
  task automatic t_inhib;
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h64);
    wr(8'h20, 32'h0201);
    wr(8'h28, 32'h21);
    ext_req <= 5'h1;
    resid[0] <= 16'hC8;
    cyc(34 * CYC);
    chk(32'({op, relay}), 32'h001);
    ext_req <= 5'h2;
    cyc(4);
    chk(32'({op, relay}), 32'h103);
    im_req <= 3'h1;
    cyc(4);
    chk(32'({op, relay}), 32'h001);
    quiet;
  endtask : t_inhib
  initial
  begin
    cyc(8);
    i_rst <= 1'h0;
    t_regs;
    t_resid;
    t_hiz;
    t_harm;
    t_inhib;
    wrap_up;
  end
endmodule : efsb_top_tb
